// ==== common/pfp_pkg.sv ====
// Constants, register map and carrier types for PWM fault input processing.
// Assumes one 125 MHz clock and a 32-bit AXI4-Lite register port.
package pfp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EVCTL_A = 8'h04;
  localparam logic [7:0] OFF_EVCTL_B = 8'h08;
  localparam logic [7:0] OFF_FCTL_A = 8'h0C;
  localparam logic [7:0] OFF_FCTL_B = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_LEN_BASE = 8'h18;
  localparam logic [7:0] OFF_GRAB_A = 8'h28;
  localparam logic [7:0] OFF_GRAB_B = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned STAT_PHASE_LSB = 16;
  localparam int unsigned STAT_HOLD_BIT = 18;
  localparam int unsigned STAT_WAIT_BIT = 19;
  localparam int unsigned STAT_LVL_LSB = 20;
  localparam int unsigned FM_W = 4;
  localparam logic [15:0] LEN_RESET = 16'h0003;
  localparam int unsigned FILTER_CYCLES = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Fault action select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FM_NONE = 4'h0;
  localparam logic [3:0] FM_JUMP_WAIT = 4'h1;
  localparam logic [3:0] FM_RUN_OPP = 4'h2;
  localparam logic [3:0] FM_REPEAT = 4'h3;
  localparam logic [3:0] FM_BLOCK = 4'h4;
  localparam logic [3:0] FM_DEAD_ONLY = 4'h5;
  localparam logic [3:0] FM_END_WAIT = 4'h6;

  typedef enum logic [1:0] {
    PH_DTA = 2'b00,
    PH_OTA = 2'b01,
    PH_DTB = 2'b10,
    PH_OTB = 2'b11
  } pfp_phase_t;

  typedef struct packed {
    logic capture;
    logic async_en;
    logic filter;
    logic enable;
  } pfp_evcfg_t;

  typedef struct packed {
    logic grab_b;
    logic grab_a;
    logic restart;
    logic now;
    logic eoc;
  } pfp_cmd_t;

endpackage

// ==== rtl/pfp_fault_timer.sv ====
// Dead-time PWM timer core with two fault/event inputs and command strobes.
// Assumes event inputs synchronous to aclk and an AXI4-Lite master.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pfp_fault_timer #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned FILT_LEN = pfp_pkg::FILTER_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic event_in_a,
  input wire logic event_in_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic waveform_out_a,
  output logic waveform_out_b
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt
    $error("CNT_W must lie in 2..16");
  end
  if (FILT_LEN < 2 || FILT_LEN > 8) begin : g_bad_filt
    $error("FILT_LEN must lie in 2..8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] ev_in;
  logic [1:0] s1_reg, s2_reg, filt_reg, flow_d_reg;
  logic [1:0][FILT_LEN-2:0] fsh_reg;
  logic [1:0] flow_lvl, ovr_lvl, rise;
  logic ctrl_en_reg;
  pfp_pkg::pfp_evcfg_t [1:0] evcfg_reg;
  logic [1:0][pfp_pkg::FM_W-1:0] fsel_reg;
  logic [3:0][CNT_W-1:0] buf_len_reg, act_len_reg;
  logic [CNT_W-1:0] cnt_reg, grab_a_reg, grab_b_reg;
  pfp_pkg::pfp_phase_t phase_reg;
  logic hold_reg, wait6_reg, pend_eoc_reg;
  logic [1:0] holdm_reg, pend2_reg;
  pfp_pkg::pfp_cmd_t cmd;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire, phase_end, cyc_end, any5, any6, kill_a, kill_b, release_ok;
  logic [31:0] rd_word;

  assign ev_in = {event_in_b, event_in_a};

  function automatic logic opp_mode(input logic [3:0] m);
    opp_mode = (m == pfp_pkg::FM_JUMP_WAIT) || (m == pfp_pkg::FM_RUN_OPP) ||
               (m == pfp_pkg::FM_REPEAT);
  endfunction

  function automatic logic own_phase(input pfp_pkg::pfp_phase_t p,
                                     input int unsigned idx);
    own_phase = (idx == 0) ? (p == pfp_pkg::PH_DTA || p == pfp_pkg::PH_OTA)
                           : (p == pfp_pkg::PH_DTB || p == pfp_pkg::PH_OTB);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= pfp_pkg::OFF_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Input conditioning: synchroniser and digital filter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      fsh_reg <= '0;
      filt_reg <= '0;
      flow_d_reg <= '0;
    end else begin
      s1_reg <= ev_in;
      s2_reg <= s1_reg;
      flow_d_reg <= flow_lvl;
      for (int i = 0; i < 2; i++) begin
        // Oldest sample drops off the top of the window
        fsh_reg[i] <= (FILT_LEN-1)'({fsh_reg[i], ev_in[i]});
        if (&{fsh_reg[i], ev_in[i]}) begin
          filt_reg[i] <= 1'b1;
        end else if (~|{fsh_reg[i], ev_in[i]}) begin
          filt_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Async override uses the raw level two flops ahead of the flow path;
  // filter takes precedence if software sets both.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      flow_lvl[i] = evcfg_reg[i].enable &
                    (evcfg_reg[i].filter ? filt_reg[i] : s2_reg[i]);
      ovr_lvl[i] = evcfg_reg[i].enable & (evcfg_reg[i].filter ? filt_reg[i]
                   : (evcfg_reg[i].async_en ? ev_in[i] : s2_reg[i]));
      rise[i] = flow_lvl[i] & ~flow_d_reg[i];
    end
  end

  // ----------------------------------------------------------------
  // Fault action decode
  // ----------------------------------------------------------------
  always_comb begin
    any5 = (flow_lvl[0] && fsel_reg[0] == pfp_pkg::FM_DEAD_ONLY) ||
           (flow_lvl[1] && fsel_reg[1] == pfp_pkg::FM_DEAD_ONLY);
    any6 = (flow_lvl[0] && fsel_reg[0] == pfp_pkg::FM_END_WAIT) ||
           (flow_lvl[1] && fsel_reg[1] == pfp_pkg::FM_END_WAIT);
    kill_b = 1'b0;
    kill_a = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (ovr_lvl[i] && (fsel_reg[i] == pfp_pkg::FM_BLOCK ||
          fsel_reg[i] == pfp_pkg::FM_DEAD_ONLY ||
          fsel_reg[i] == pfp_pkg::FM_END_WAIT)) begin
        kill_a = 1'b1;
        kill_b = 1'b1;
      end
    end
    if (ovr_lvl[0] && opp_mode(fsel_reg[0])) begin
      kill_a = 1'b1;
    end
    if (ovr_lvl[1] && opp_mode(fsel_reg[1])) begin
      kill_b = 1'b1;
    end
    release_ok = !((holdm_reg[0] && flow_lvl[0]) ||
                   (holdm_reg[1] && flow_lvl[1]));
    phase_end = (cnt_reg == act_len_reg[phase_reg]);
    cyc_end = ctrl_en_reg && !hold_reg && !wait6_reg && phase_end &&
              phase_reg == pfp_pkg::PH_OTB;
  end

  // ----------------------------------------------------------------
  // Phase sequencer and counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= pfp_pkg::PH_DTA;
      cnt_reg <= '0;
      hold_reg <= 1'b0;
      holdm_reg <= '0;
      pend2_reg <= '0;
      wait6_reg <= 1'b0;
    end else if (!ctrl_en_reg || cmd.restart) begin
      phase_reg <= pfp_pkg::PH_DTA;
      cnt_reg <= '0;
      hold_reg <= 1'b0;
      holdm_reg <= '0;
      pend2_reg <= '0;
      wait6_reg <= 1'b0;
    end else if (hold_reg) begin
      if (release_ok) begin
        hold_reg <= 1'b0;
        holdm_reg <= '0;
      end
    end else if (wait6_reg) begin
      if (!any6) begin
        wait6_reg <= 1'b0;
        cnt_reg <= '0;
        phase_reg <= (phase_reg == pfp_pkg::PH_DTA) ? pfp_pkg::PH_DTB
                                                    : pfp_pkg::PH_DTA;
      end
    end else if (flow_lvl[0] && opp_mode(fsel_reg[0]) &&
                 own_phase(phase_reg, 0)) begin
      phase_reg <= pfp_pkg::PH_DTB;
      cnt_reg <= '0;
      hold_reg <= (fsel_reg[0] == pfp_pkg::FM_JUMP_WAIT);
      holdm_reg[0] <= (fsel_reg[0] == pfp_pkg::FM_JUMP_WAIT);
      pend2_reg[0] <= (fsel_reg[0] == pfp_pkg::FM_RUN_OPP);
    end else if (flow_lvl[1] && opp_mode(fsel_reg[1]) &&
                 own_phase(phase_reg, 1)) begin
      phase_reg <= pfp_pkg::PH_DTA;
      cnt_reg <= '0;
      hold_reg <= (fsel_reg[1] == pfp_pkg::FM_JUMP_WAIT);
      holdm_reg[1] <= (fsel_reg[1] == pfp_pkg::FM_JUMP_WAIT);
      pend2_reg[1] <= (fsel_reg[1] == pfp_pkg::FM_RUN_OPP);
    end else if ((any5 || any6) && phase_reg == pfp_pkg::PH_OTA) begin
      phase_reg <= pfp_pkg::PH_DTB;
      cnt_reg <= '0;
    end else if ((any5 || any6) && phase_reg == pfp_pkg::PH_OTB) begin
      phase_reg <= pfp_pkg::PH_DTA;
      cnt_reg <= '0;
    end else if (phase_end) begin
      cnt_reg <= '0;
      case (phase_reg)
        pfp_pkg::PH_DTA, pfp_pkg::PH_DTB: begin
          if (any5) begin
            phase_reg <= (phase_reg == pfp_pkg::PH_DTA) ? pfp_pkg::PH_DTB
                                                        : pfp_pkg::PH_DTA;
          end else if (any6) begin
            wait6_reg <= 1'b1;
            cnt_reg <= cnt_reg;
          end else begin
            phase_reg <= (phase_reg == pfp_pkg::PH_DTA) ? pfp_pkg::PH_OTA
                                                        : pfp_pkg::PH_OTB;
          end
        end
        pfp_pkg::PH_OTA: begin
          pend2_reg[1] <= 1'b0;
          hold_reg <= pend2_reg[1] && flow_lvl[1];
          holdm_reg[1] <= pend2_reg[1] && flow_lvl[1];
          phase_reg <= (flow_lvl[1] && fsel_reg[1] == pfp_pkg::FM_REPEAT)
                       ? pfp_pkg::PH_DTA : pfp_pkg::PH_DTB;
        end
        default: begin
          pend2_reg[0] <= 1'b0;
          hold_reg <= pend2_reg[0] && flow_lvl[0];
          holdm_reg[0] <= pend2_reg[0] && flow_lvl[0];
          phase_reg <= (flow_lvl[0] && fsel_reg[0] == pfp_pkg::FM_REPEAT)
                       ? pfp_pkg::PH_DTB : pfp_pkg::PH_DTA;
        end
      endcase
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Outputs stay flop-driven; async override lands on the next edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waveform_out_a <= 1'b0;
      waveform_out_b <= 1'b0;
    end else begin
      waveform_out_a <= ctrl_en_reg && phase_reg == pfp_pkg::PH_OTA &&
                        !kill_a;
      waveform_out_b <= ctrl_en_reg && phase_reg == pfp_pkg::PH_OTB &&
                        !kill_b;
    end
  end

  // ----------------------------------------------------------------
  // Double-buffered lengths and grab registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_len_reg <= {4{pfp_pkg::LEN_RESET[CNT_W-1:0]}};
      pend_eoc_reg <= 1'b0;
    end else begin
      if (cmd.now) begin
        act_len_reg <= buf_len_reg;
      end else if (cyc_end && pend_eoc_reg) begin
        act_len_reg <= buf_len_reg;
      end
      // A new strobe in the update cycle wins over the clear.
      if (cmd.eoc) begin
        pend_eoc_reg <= 1'b1;
      end else if (cyc_end || cmd.now) begin
        pend_eoc_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grab_a_reg <= '0;
      grab_b_reg <= '0;
    end else begin
      if (cmd.grab_a || (evcfg_reg[0].capture && rise[0])) begin
        grab_a_reg <= cnt_reg;
      end
      if (cmd.grab_b || (evcfg_reg[1].capture && rise[1])) begin
        grab_b_reg <= cnt_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel and register writes
  // ----------------------------------------------------------------
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pfp_pkg::RESP_OKAY;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(waddr_reg) ? pfp_pkg::RESP_OKAY
                                         : pfp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Command strobes last one cycle; a write of zero does nothing.
  assign cmd = (wr_fire && waddr_reg == pfp_pkg::OFF_CMD && wstrb_reg[0])
               ? pfp_pkg::pfp_cmd_t'(wdata_reg[4:0]) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_reg <= 1'b0;
      evcfg_reg <= '0;
      fsel_reg <= '0;
      buf_len_reg <= {4{pfp_pkg::LEN_RESET[CNT_W-1:0]}};
    end else if (wr_fire) begin
      if (waddr_reg == pfp_pkg::OFF_CTRL) begin
        if (wstrb_reg[0]) begin
          ctrl_en_reg <= wdata_reg[pfp_pkg::CTRL_EN_BIT];
        end
      end else if (waddr_reg == pfp_pkg::OFF_EVCTL_A && wstrb_reg[0]) begin
        evcfg_reg[0] <= wdata_reg[3:0];
      end else if (waddr_reg == pfp_pkg::OFF_EVCTL_B && wstrb_reg[0]) begin
        evcfg_reg[1] <= wdata_reg[3:0];
      end else if (waddr_reg == pfp_pkg::OFF_FCTL_A && wstrb_reg[0]) begin
        fsel_reg[0] <= wdata_reg[3:0];
      end else if (waddr_reg == pfp_pkg::OFF_FCTL_B && wstrb_reg[0]) begin
        fsel_reg[1] <= wdata_reg[3:0];
      end else if (waddr_reg >= pfp_pkg::OFF_LEN_BASE &&
                   waddr_reg < pfp_pkg::OFF_GRAB_A) begin
        buf_len_reg[2'(waddr_reg[7:2] - pfp_pkg::OFF_LEN_BASE[7:2])] <=
          CNT_W'(merge(32'(buf_len_reg[2'(waddr_reg[7:2] -
          pfp_pkg::OFF_LEN_BASE[7:2])]), wdata_reg, wstrb_reg));
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == pfp_pkg::OFF_CTRL) begin
      rd_word[pfp_pkg::CTRL_EN_BIT] = ctrl_en_reg;
    end else if (s_axi_araddr == pfp_pkg::OFF_EVCTL_A) begin
      rd_word[3:0] = evcfg_reg[0];
    end else if (s_axi_araddr == pfp_pkg::OFF_EVCTL_B) begin
      rd_word[3:0] = evcfg_reg[1];
    end else if (s_axi_araddr == pfp_pkg::OFF_FCTL_A) begin
      rd_word[3:0] = fsel_reg[0];
    end else if (s_axi_araddr == pfp_pkg::OFF_FCTL_B) begin
      rd_word[3:0] = fsel_reg[1];
    end else if (s_axi_araddr >= pfp_pkg::OFF_LEN_BASE &&
                 s_axi_araddr < pfp_pkg::OFF_GRAB_A) begin
      rd_word[CNT_W-1:0] = buf_len_reg[2'(s_axi_araddr[7:2] -
                                          pfp_pkg::OFF_LEN_BASE[7:2])];
    end else if (s_axi_araddr == pfp_pkg::OFF_GRAB_A) begin
      rd_word[CNT_W-1:0] = grab_a_reg;
    end else if (s_axi_araddr == pfp_pkg::OFF_GRAB_B) begin
      rd_word[CNT_W-1:0] = grab_b_reg;
    end else if (s_axi_araddr == pfp_pkg::OFF_STATUS) begin
      rd_word[CNT_W-1:0] = cnt_reg;
      rd_word[pfp_pkg::STAT_PHASE_LSB +: 2] = phase_reg;
      rd_word[pfp_pkg::STAT_HOLD_BIT] = hold_reg;
      rd_word[pfp_pkg::STAT_WAIT_BIT] = wait6_reg;
      rd_word[pfp_pkg::STAT_LVL_LSB +: 2] = flow_lvl;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pfp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= mapped(s_axi_araddr) ? pfp_pkg::RESP_OKAY
                                          : pfp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence high_four_a;
    event_in_a [*4];
  endsequence

  AST_FILT_REJECT: assert property (
    $rose(filt_reg[0]) |-> $past(event_in_a, 1) && $past(event_in_a, 2) &&
      $past(event_in_a, 3) && $past(event_in_a, 4))
    else $error("Filter passed a short pulse");
  AST_FILT_DELAY: assert property (
    (evcfg_reg[0].filter && $rose(event_in_a)) ##0 high_four_a |=> filt_reg[0])
    else $error("Filter output late");
  AST_ASYNC_OVR: assert property (
    ctrl_en_reg && evcfg_reg[0].enable && evcfg_reg[0].async_en &&
      !evcfg_reg[0].filter && event_in_a &&
      fsel_reg[0] == pfp_pkg::FM_BLOCK |=> !waveform_out_a)
    else $error("Async override missed");
  AST_SYNC_LAT: assert property (
    (evcfg_reg[0].enable && !evcfg_reg[0].async_en && !evcfg_reg[0].filter
      && fsel_reg[0] == pfp_pkg::FM_BLOCK && $rose(event_in_a))
      ##0 event_in_a [*3] |=> !waveform_out_a && !waveform_out_b)
    else $error("Sync override later than three cycles");
  AST_EOC_UPD: assert property (
    pend_eoc_reg && cyc_end && !cmd.now |=> act_len_reg == $past(buf_len_reg))
    else $error("Cycle end update missed");
  AST_NOW_UPD: assert property (
    cmd.now |=> act_len_reg == $past(buf_len_reg))
    else $error("Immediate update missed");
  AST_RESTART: assert property (
    cmd.restart |=> phase_reg == pfp_pkg::PH_DTA && cnt_reg == '0)
    else $error("Restart did not clear counter");
  AST_GRAB_A: assert property (
    cmd.grab_a |=> grab_a_reg == $past(cnt_reg))
    else $error("Grab A wrong value");
  AST_HOLD_STILL: assert property (
    hold_reg ##1 hold_reg |-> $stable(cnt_reg) && $stable(phase_reg))
    else $error("Counter moved while held");
  AST_JUMP_B: assert property (
    $rose(hold_reg) && holdm_reg[0] && !$past(pend2_reg[0]) |->
      phase_reg == pfp_pkg::PH_DTB)
    else $error("Mode one did not jump to dead-time B");

endmodule
`default_nettype wire

// ==== verif/pfp_event_source.sv ====
// Event routing model: drives the two fault inputs of the timer.
// Assumes the bench commands levels and a chopped train on input A.
`timescale 1ns/1ps
`default_nettype none
module pfp_event_source (
  input wire logic aclk,
  input wire logic lvl_a,
  input wire logic lvl_b,
  input wire logic chop_a,
  output logic event_in_a = 1'b0,
  output logic event_in_b = 1'b0
);
  logic [1:0] ph_reg = 2'h0;
  always @(posedge aclk) begin
    ph_reg <= ph_reg + 2'h1;
    // Three high, one low: every pulse is shorter than the filter span
    event_in_a <= chop_a ? (ph_reg != 2'h3) : lvl_a;
    event_in_b <= lvl_b;
  end
endmodule
`default_nettype wire

// ==== verif/pwm_fault_input_processing_test.sv ====
// Bench for the fault timer: AXI4-Lite tasks and fault scenarios.
// Assumes the event model drives both fault inputs.
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_input_processing_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [31:0] s_axi_rdata, rd_q, cnt_q;
  logic event_in_a, event_in_b, waveform_out_a, waveform_out_b;
  logic lvl_a = 1'b0, lvl_b = 1'b0, chop_a = 1'b0, hi_a, hi_b;
  int fail_count = 0;
  int checked = 0;
  initial forever #4 aclk = ~aclk;
  pfp_fault_timer dut_u (.aclk, .aresetn, .event_in_a, .event_in_b,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .waveform_out_a, .waveform_out_b);
  pfp_event_source src_u (.aclk, .lvl_a, .lvl_b, .chop_a, .event_in_a,
    .event_in_b);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Each bus task starts on a fresh edge so no signal is driven twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    wr_r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    rd_r = s_axi_rresp;
  endtask
  task automatic watch(input int n);
    hi_a = 1'b0;
    hi_b = 1'b0;
    repeat (n) begin
      @(posedge aclk);
      hi_a = hi_a | waveform_out_a;
      hi_b = hi_b | waveform_out_b;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pfp_pkg::OFF_LEN_BASE);
    chk(rd_q, {16'h0000, pfp_pkg::LEN_RESET});
    rd(8'h34);
    chk(32'(rd_r), 32'(pfp_pkg::RESP_SLVERR));
    wr(8'h34, 32'h0000_0001);
    chk(32'(wr_r), 32'(pfp_pkg::RESP_SLVERR));
    wr(pfp_pkg::OFF_CTRL, 32'h0000_0001);
    wr(pfp_pkg::OFF_EVCTL_A, 32'h0000_0001);
    lvl_a <= 1'b1;
    watch(20);
    chk(32'({hi_a, hi_b}), 32'h0000_0003);
    wr(pfp_pkg::OFF_FCTL_A, 32'(pfp_pkg::FM_BLOCK));
    rd(pfp_pkg::OFF_STATUS);
    cnt_q = rd_q;
    watch(20);
    chk(32'({hi_a, hi_b}), 32'h0000_0000);
    rd(pfp_pkg::OFF_STATUS);
    chk(32'(rd_q[15:0] !== cnt_q[15:0]), 32'h0000_0001);
    wr(pfp_pkg::OFF_EVCTL_A, 32'h0000_0003);
    // Settle the filter low first, so only the short highs are judged
    lvl_a <= 1'b0;
    repeat (6) @(posedge aclk);
    chop_a <= 1'b1;
    repeat (8) @(posedge aclk);
    watch(20);
    chk(32'({hi_a, hi_b}), 32'h0000_0003);
    chop_a <= 1'b0;
    lvl_a <= 1'b1;
    repeat (8) @(posedge aclk);
    watch(20);
    chk(32'({hi_a, hi_b}), 32'h0000_0000);
    wr(pfp_pkg::OFF_EVCTL_A, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    watch(20);
    chk(32'({hi_a, hi_b}), 32'h0000_0003);
    // Async override lands 2 edges after lvl_a is set, sync path 4
    for (int i = 0; i < 2; i++) begin
      lvl_a <= 1'b0;
      wr(pfp_pkg::OFF_EVCTL_A, (i == 0) ? 32'h0000_0005 : 32'h0000_0001);
      repeat (8) @(posedge aclk);
      lvl_a <= 1'b1;
      repeat ((i == 0) ? 2 : 4) @(posedge aclk);
      watch(20);
      chk(32'({hi_a, hi_b}), 32'h0000_0000);
    end
    wr(pfp_pkg::OFF_FCTL_A, 32'(pfp_pkg::FM_JUMP_WAIT));
    repeat (20) @(posedge aclk);
    rd(pfp_pkg::OFF_STATUS);
    chk(32'({rd_q[18], waveform_out_a}), 32'h0000_0002);
    lvl_a <= 1'b0;
    wr(pfp_pkg::OFF_FCTL_A, 32'(pfp_pkg::FM_NONE));
    wr(pfp_pkg::OFF_EVCTL_B, 32'h0000_0001);
    wr(pfp_pkg::OFF_FCTL_B, 32'(pfp_pkg::FM_END_WAIT));
    lvl_b <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(pfp_pkg::OFF_STATUS);
    chk(32'({rd_q[19], waveform_out_a, waveform_out_b}), 32'h0000_0004);
    wr(pfp_pkg::OFF_FCTL_B, 32'(pfp_pkg::FM_DEAD_ONLY));
    repeat (20) @(posedge aclk);
    rd(pfp_pkg::OFF_STATUS);
    chk(32'({rd_q[16], waveform_out_a, waveform_out_b}), 32'h0000_0000);
    wr(pfp_pkg::OFF_FCTL_B, 32'(pfp_pkg::FM_REPEAT));
    repeat (20) @(posedge aclk);
    watch(20);
    chk(32'({hi_a, hi_b}), 32'h0000_0002);
    lvl_b <= 1'b0;
    wr(pfp_pkg::OFF_FCTL_B, 32'(pfp_pkg::FM_NONE));
    wr(pfp_pkg::OFF_LEN_BASE, 32'h0000_001f);
    wr(pfp_pkg::OFF_CMD, 32'h0000_0006);
    repeat (8) @(posedge aclk);
    rd(pfp_pkg::OFF_STATUS);
    chk(32'(rd_q[17:16]), 32'h0000_0000);
    wr(pfp_pkg::OFF_CMD, 32'h0000_0008);
    rd(pfp_pkg::OFF_GRAB_A);
    chk(32'(rd_q > 32'h0000_0008 && rd_q < 32'h0000_0020), 32'h0000_0001);
    rd(pfp_pkg::OFF_GRAB_B);
    chk(rd_q, 32'h0000_0000);
    // Dead-time A shrinks from 32 to 4 cycles only once the cycle ends
    wr(pfp_pkg::OFF_LEN_BASE, 32'h0000_0003);
    wr(pfp_pkg::OFF_CMD, 32'h0000_0005);
    repeat (8) @(posedge aclk);
    rd(pfp_pkg::OFF_STATUS);
    chk(32'(rd_q[17:16]), 32'h0000_0000);
    repeat (37) @(posedge aclk);
    rd(pfp_pkg::OFF_STATUS);
    chk(32'(rd_q[17:16]), 32'h0000_0001);
    wr(pfp_pkg::OFF_CMD, 32'h0000_0010);
    rd(pfp_pkg::OFF_GRAB_B);
    chk(rd_q, 32'h0000_0002);
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
